// [bench/loop_ramp_config_chk.sv]
`timescale 1ns/10ps
module loop_ramp_config_chk #(
   parameter int TICK_CYCLES = 8
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_RD,
   input wire logic [31:0] REG_RDATA,
   input wire logic [15:0] VREF_APPLIED,
   input wire logic CONTROL_TICK,
   input wire logic COMM_VARIABLE,
   input wire logic [6:0] PWM_FREQ_KHZ,
   input wire logic [1:0] MOD_SIDE,
   input wire logic PWM_COMPLEMENTARY,
   input wire logic signed [12:0] ADVANCE_CENTIDEG
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   logic [31:0] d1_q, d2_q;
   logic [12:0] adv;
   int gap_q;
   // Cycles since the last tick, restarting at one on a tick
   always_ff @(posedge CLK) begin
      if (RST) begin
         gap_q <= 0;
      end else if (CONTROL_TICK) begin
         gap_q <= 1;
      end else begin
         gap_q <= gap_q + 1;
      end
   end
   // Write data delayed two edges lines up with the decoded outputs
   always_ff @(posedge CLK) begin
      d1_q <= REG_WDATA;
      d2_q <= d1_q;
   end
   assign adv = 13'(d2_q[8:1]) * 13'h000C;
   ////////////////////////////////////////////////////////////////////////////
   sequence wr_cfg;
      REG_WR && REG_ADDR == 8'h86;
   endsequence
   sequence rd_cfg;
      REG_RD && !REG_WR && REG_ADDR == 8'h86;
   endsequence
   a_read_back: assert property (wr_cfg ##1 rd_cfg |=> REG_RDATA == $past(REG_WDATA, 2))
      else $error("bad readback");
   a_comm_decode: assert property (wr_cfg |-> ##2 COMM_VARIABLE == (d2_q[30:29] == 2'h1))
      else $error("bad commutation");
   a_freq_decode: assert property (wr_cfg |-> ##2 PWM_FREQ_KHZ ==
      (d2_q[17] ? 7'h19 + 7'h05 * d2_q[16:13] : 7'h05 + d2_q[16:13])) else $error("bad frequency");
   a_side_decode: assert property (wr_cfg |-> ##2 MOD_SIDE == (d2_q[12:11] == 2'h3 ? 2'h0 : d2_q[12:11]))
      else $error("bad modulation");
   a_mode_decode: assert property (wr_cfg |-> ##2 PWM_COMPLEMENTARY == d2_q[10])
      else $error("bad pwm mode");
   a_lead_angle: assert property (wr_cfg |-> ##2 ADVANCE_CENTIDEG == (d2_q[9] ? adv : -adv))
      else $error("bad lead angle");
   a_tick_period: assert property (CONTROL_TICK |-> gap_q == TICK_CYCLES)
      else $error("bad tick period");
   a_tick_missing: assert property (gap_q == TICK_CYCLES |-> CONTROL_TICK)
      else $error("tick missing");
   a_ramp_on_tick: assert property ($changed(VREF_APPLIED) |-> CONTROL_TICK)
      else $error("ramp moved off tick");
   a_unmapped_rd: assert property (REG_RD && REG_ADDR != 8'h86 |=> REG_RDATA == 32'h00000000)
      else $error("unmapped read not zero");
endmodule // loop_ramp_config_chk

// [bench/tb.sv]
`timescale 1ns/10ps
module tb;
   logic CLK, RST, REG_WR, REG_RD, CONTROL_TICK, COMM_VARIABLE, PWM_COMPLEMENTARY, RAMP_ACTIVE;
   logic [7:0] REG_ADDR;
   logic [31:0] REG_WDATA, REG_RDATA, w, r;
   logic [15:0] VREF_TARGET, VREF_APPLIED;
   logic [6:0] PWM_FREQ_KHZ, f;
   logic [1:0] MOD_SIDE;
   logic signed [12:0] ADVANCE_CENTIDEG;
   logic [12:0] a;
   logic [31:0] tbl [4] = '{32'hFFFFFFFF, 32'hA0000001, 32'h4001E802, 32'h00021700};
   int n_fail = 0;
   int comparisons = 0;
   // Short tick keeps every ramp but the slowest fall code within about a hundred cycles
   loop_ramp_config #(.TICK_CYCLES(8)) i_dut (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
      .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .VREF_TARGET(VREF_TARGET),
      .VREF_APPLIED(VREF_APPLIED), .RAMP_ACTIVE(RAMP_ACTIVE), .CONTROL_TICK(CONTROL_TICK),
      .COMM_VARIABLE(COMM_VARIABLE),
      .PWM_FREQ_KHZ(PWM_FREQ_KHZ), .MOD_SIDE(MOD_SIDE), .PWM_COMPLEMENTARY(PWM_COMPLEMENTARY),
      .ADVANCE_CENTIDEG(ADVANCE_CENTIDEG));
   initial begin
      CLK = 1'b0;
      forever #2.5 CLK = ~CLK;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         n_fail++;
         $display("ERROR at %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge CLK);
      REG_ADDR <= ad;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge CLK);
      REG_WR <= 1'b0;
   endtask
   // Starts at the current edge so it can follow a write back to back
   task automatic rd(input logic [7:0] ad, output logic [31:0] d);
      REG_ADDR <= ad;
      REG_RD <= 1'b1;
      @(posedge CLK);
      REG_RD <= 1'b0;
      @(negedge CLK);
      d = REG_RDATA;
   endtask
   task automatic rmp(input logic [31:0] v, input logic [15:0] t);
      wr(8'h86, v);
      VREF_TARGET <= t;
      repeat (100) @(posedge CLK);
      @(negedge CLK);
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      RST = 1'b1;
      REG_ADDR = 8'h00;
      REG_WR = 1'b0;
      REG_WDATA = 32'h00000000;
      REG_RD = 1'b0;
      VREF_TARGET = 16'h0000;
      repeat (12) @(posedge CLK);
      RST <= 1'b0;
      rd(8'h86, r);
      chk(r, 32'h00000000);
      chk({25'h0, PWM_FREQ_KHZ}, 32'h00000005);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         w = tbl[i];
         wr(8'h86, w);
         rd(8'h86, r);
         @(negedge CLK);
         chk(r, w);
         chk({31'h0, COMM_VARIABLE}, {31'h0, w[30:29] == 2'h1});
         f = w[17] ? 7'h19 + 7'h05 * w[16:13] : 7'h05 + w[16:13];
         chk({25'h0, PWM_FREQ_KHZ}, {25'h0, f});
         chk({30'h0, MOD_SIDE}, {30'h0, w[12:11] == 2'h3 ? 2'h0 : w[12:11]});
         chk({31'h0, PWM_COMPLEMENTARY}, {31'h0, w[10]});
         a = 13'(w[8:1]) * 13'h000C;
         chk({19'h0, ADVANCE_CENTIDEG}, {19'h0, w[9] ? a : -a});
      end
      $display("test fields done");
      wr(8'h85, 32'h12345678);
      rd(8'h87, r);
      chk(r, 32'h00000000);
      wr(8'h85, 32'h0000FFFF);
      rd(8'h86, r);
      chk(r, tbl[3]);
      $display("test unmapped done");
      rmp(32'h1F000000, 16'h000A);
      chk({16'h0, VREF_APPLIED}, 32'h0000000A);
      // Slowest fall code barely moves in a hundred cycles
      rmp(32'h1F000000, 16'h0000);
      chk({31'h0, VREF_APPLIED > 16'h0008}, 32'h00000001);
      chk({31'h0, RAMP_ACTIVE}, 32'h00000001);
      rmp(32'h1F800000, 16'h0000);
      chk({16'h0, VREF_APPLIED}, 32'h00000000);
      chk({31'h0, RAMP_ACTIVE}, 32'h00000000);
      rmp(32'h1F7C0000, 16'h000A);
      rmp(32'h1F7C0000, 16'h0000);
      chk({16'h0, VREF_APPLIED}, 32'h00000000);
      $display("test ramp done");
      wrap_up;
   end
   initial begin
      repeat (3000) @(posedge CLK);
      n_fail++;
      wrap_up;
   end
endmodule // tb
bind loop_ramp_config loop_ramp_config_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.CLK(CLK), .RST(RST),
   .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
   .VREF_APPLIED(VREF_APPLIED), .CONTROL_TICK(CONTROL_TICK), .COMM_VARIABLE(COMM_VARIABLE),
   .PWM_FREQ_KHZ(PWM_FREQ_KHZ), .MOD_SIDE(MOD_SIDE), .PWM_COMPLEMENTARY(PWM_COMPLEMENTARY),
   .ADVANCE_CENTIDEG(ADVANCE_CENTIDEG));

// [inc/loop_cfg_pkg.sv]
// Operation
// - Bits 30:29 select commutation; code 0 is fixed 120 degree trapezoidal.
// - Code 1 varies commutation between 120 and 150 degrees; codes 2, 3 unused.
// - Bits 28:24 hold the rise rate code, 0.005 V/s up to 32767 V/s.
// - Bit 23 zero: falling ramp uses the separate fall rate code.
// - Bit 23 one: falling ramp reuses the rise rate, fall code ignored.
// - Bits 22:18 hold the fall rate code, same table as rise.
// - Bits 17:13 pick switching frequency, 5-20 kHz by 1, 25-100 kHz by 5.
// - Bits 12:11 pick high-side, low-side or mixed modulation; code 3 unused.
// - Bit 10 picks single-ended when zero, complementary when one.
// - Bit 9 is advance sign; bits 8:1 give angle as code times 0.12 degree.
package loop_cfg_pkg;

   ////////////////////////////////////////////////////////////////////////////
   localparam logic [7:0] SETUP_A_OFFSET = 8'h86;
   localparam logic [31:0] SETUP_A_RESET = 32'h00000000;

   // Field layout, MSB first, matches the register word
   typedef struct packed {
      logic parity;
      logic [1:0] commutation_select;
      logic [4:0] loop_rise_rate;
      logic loop_fall_source;
      logic [4:0] loop_fall_rate;
      logic [4:0] pwm_freq_code;
      logic [1:0] modulation_side;
      logic pwm_complementary;
      logic advance_sign;
      logic [7:0] advance_angle;
      logic reserved0;
   } setup_a_t;

   typedef enum logic [1:0] {
      COMM_FIXED_120 = 2'b00,
      COMM_VARIABLE = 2'b01
   } comm_mode_t;

   typedef enum logic [1:0] {
      MOD_HIGH_SIDE = 2'b00,
      MOD_LOW_SIDE = 2'b01,
      MOD_MIXED = 2'b10
   } mod_side_t;

   typedef enum logic [1:0] {
      RAMP_HOLD = 2'b00,
      RAMP_RISE = 2'b01,
      RAMP_FALL = 2'b10
   } ramp_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // Ramp rates in mV/s, indexed by the 5-bit code
   localparam int RATE_CODES = 32;
   localparam longint RATE_MVPS [RATE_CODES] = '{
      5, 10, 25, 50, 100, 250, 500, 1000,
      2500, 5000, 7500, 10000, 12500, 15000, 20000, 30000,
      40000, 50000, 60000, 75000, 100000, 125000, 150000, 175000,
      200000, 250000, 300000, 400000, 500000, 750000, 1000000, 32767000};

   localparam int STEP_W = 32;
   localparam int STEP_FRAC_BITS = 16;
   localparam int VREF_W = 16;
   localparam longint NS_PER_S = 64'd1000000000;

   localparam logic [6:0] PWM_LOW_BASE_KHZ = 7'h05;
   localparam logic [6:0] PWM_LOW_STEP_KHZ = 7'h01;
   localparam logic [6:0] PWM_HIGH_BASE_KHZ = 7'h19;
   localparam logic [6:0] PWM_HIGH_STEP_KHZ = 7'h05;

   localparam logic [12:0] ADVANCE_CENTIDEG_PER_CODE = 13'h000C;

   localparam int CLK_PERIOD_NS = 5;
   localparam int TICK_PERIOD_NS = 100000;
   localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

endpackage

// [verilog/loop_ramp_config.sv]
`timescale 1ns/10ps
module loop_ramp_config #(
   parameter int TICK_CYCLES = loop_cfg_pkg::TICK_CYCLES
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   input wire logic [loop_cfg_pkg::VREF_W-1:0] VREF_TARGET,
   output logic [loop_cfg_pkg::VREF_W-1:0] VREF_APPLIED,
   output logic RAMP_ACTIVE,
   output logic CONTROL_TICK,
   output logic COMM_VARIABLE,
   output logic [6:0] PWM_FREQ_KHZ,
   output logic [1:0] MOD_SIDE,
   output logic PWM_COMPLEMENTARY,
   output logic signed [12:0] ADVANCE_CENTIDEG
);

   ////////////////////////////////////////////////////////////////////////////
   // Register access
   loop_cfg_pkg::setup_a_t cfg_q, cfg_d;
   logic [31:0] rdata_q, rdata_d;
   logic hit;

   always_comb begin
      hit = (REG_ADDR == loop_cfg_pkg::SETUP_A_OFFSET);
      cfg_d = cfg_q;
      rdata_d = rdata_q;
      if (REG_WR && hit) begin
         cfg_d = loop_cfg_pkg::setup_a_t'(REG_WDATA);
      end
      if (REG_RD) begin
         // Unmapped addresses read as zero
         rdata_d = hit ? 32'(cfg_q) : 32'h00000000;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         cfg_q <= loop_cfg_pkg::setup_a_t'(loop_cfg_pkg::SETUP_A_RESET);
         rdata_q <= 32'h00000000;
      end else begin
         cfg_q <= cfg_d;
         rdata_q <= rdata_d;
      end
   end

   assign REG_RDATA = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // Decoded configuration, registered so outputs come straight from flops
   logic comm_var_q, comm_var_d;
   logic [6:0] pwm_khz_q, pwm_khz_d;
   logic [1:0] mod_q, mod_d;
   logic compl_q, compl_d;
   logic signed [12:0] adv_q, adv_d;
   logic [12:0] adv_mag;

   always_comb begin
      // Unused codes 2 and 3 fall back to fixed 120 degree operation
      comm_var_d = (cfg_q.commutation_select == loop_cfg_pkg::COMM_VARIABLE);
      if (cfg_q.pwm_freq_code[4]) begin
         pwm_khz_d = loop_cfg_pkg::PWM_HIGH_BASE_KHZ
                     + 7'(loop_cfg_pkg::PWM_HIGH_STEP_KHZ * 7'(cfg_q.pwm_freq_code[3:0]));
      end else begin
         pwm_khz_d = loop_cfg_pkg::PWM_LOW_BASE_KHZ
                     + 7'(loop_cfg_pkg::PWM_LOW_STEP_KHZ * 7'(cfg_q.pwm_freq_code[3:0]));
      end
      case (cfg_q.modulation_side)
         loop_cfg_pkg::MOD_LOW_SIDE: mod_d = loop_cfg_pkg::MOD_LOW_SIDE;
         loop_cfg_pkg::MOD_MIXED: mod_d = loop_cfg_pkg::MOD_MIXED;
         // Code 3 has no meaning; high-side is the safe default
         default: mod_d = loop_cfg_pkg::MOD_HIGH_SIDE;
      endcase
      compl_d = cfg_q.pwm_complementary;
      adv_mag = 13'(loop_cfg_pkg::ADVANCE_CENTIDEG_PER_CODE * 13'(cfg_q.advance_angle));
      adv_d = cfg_q.advance_sign ? $signed(adv_mag) : -$signed(adv_mag);
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         comm_var_q <= 1'b0;
         pwm_khz_q <= loop_cfg_pkg::PWM_LOW_BASE_KHZ;
         mod_q <= 2'h0;
         compl_q <= 1'b0;
         adv_q <= 13'sh0000;
      end else begin
         comm_var_q <= comm_var_d;
         pwm_khz_q <= pwm_khz_d;
         mod_q <= mod_d;
         compl_q <= compl_d;
         adv_q <= adv_d;
      end
   end

   assign COMM_VARIABLE = comm_var_q;
   assign PWM_FREQ_KHZ = pwm_khz_q;
   assign MOD_SIDE = mod_q;
   assign PWM_COMPLEMENTARY = compl_q;
   assign ADVANCE_CENTIDEG = adv_q;

   ////////////////////////////////////////////////////////////////////////////
   // Control tick
   localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
   logic [31:0] tick_cnt_q, tick_cnt_d;
   logic tick_q, tick_d;

   always_comb begin
      tick_d = (tick_cnt_q == TICK_LAST);
      tick_cnt_d = tick_d ? 32'h00000000 : tick_cnt_q + 32'h00000001;
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         tick_cnt_q <= 32'h00000000;
         tick_q <= 1'b0;
      end else begin
         tick_cnt_q <= tick_cnt_d;
         tick_q <= tick_d;
      end
   end

   assign CONTROL_TICK = tick_q;

   ////////////////////////////////////////////////////////////////////////////
   // Slope limiter on the applied voltage reference
   logic [4:0] fall_code;
   logic [4:0] rate_code;
   logic [loop_cfg_pkg::STEP_W-1:0] step;
   logic [31:0] ref_q, ref_d;
   logic [31:0] target_w;
   logic [31:0] gap;
   loop_cfg_pkg::ramp_state_t state_q, state_d;

   // Rise code is reused for falling when the source bit is set
   assign fall_code = cfg_q.loop_fall_source ? cfg_q.loop_rise_rate : cfg_q.loop_fall_rate;
   assign rate_code = (state_d == loop_cfg_pkg::RAMP_FALL) ? fall_code : cfg_q.loop_rise_rate;

   rate_step_rom #(
      .TICK_NS(TICK_CYCLES * loop_cfg_pkg::CLK_PERIOD_NS)
   ) u_rate (
      .code(rate_code),
      .step(step)
   );

   always_comb begin
      target_w = {VREF_TARGET, 16'h0000};
      gap = 32'h00000000;
      ref_d = ref_q;
      if (target_w > ref_q) begin
         state_d = loop_cfg_pkg::RAMP_RISE;
      end else if (target_w < ref_q) begin
         state_d = loop_cfg_pkg::RAMP_FALL;
      end else begin
         state_d = loop_cfg_pkg::RAMP_HOLD;
      end
      // Moves only on a tick so the slope is independent of clock rate
      if (tick_d) begin
         case (state_d)
            loop_cfg_pkg::RAMP_RISE: begin
               gap = target_w - ref_q;
               ref_d = (gap <= step) ? target_w : ref_q + step;
            end
            loop_cfg_pkg::RAMP_FALL: begin
               gap = ref_q - target_w;
               ref_d = (gap <= step) ? target_w : ref_q - step;
            end
            default: ref_d = ref_q;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         ref_q <= 32'h00000000;
         state_q <= loop_cfg_pkg::RAMP_HOLD;
      end else begin
         ref_q <= ref_d;
         state_q <= state_d;
      end
   end

   assign VREF_APPLIED = ref_q[31:16];
   assign RAMP_ACTIVE = (state_q != loop_cfg_pkg::RAMP_HOLD);

endmodule // loop_ramp_config

// [verilog/rate_step_rom.sv]
`timescale 1ns/10ps
module rate_step_rom #(
   parameter int TICK_NS = loop_cfg_pkg::TICK_PERIOD_NS
) (
   input wire logic [4:0] code,
   output logic [loop_cfg_pkg::STEP_W-1:0] step
);

   logic [loop_cfg_pkg::STEP_W-1:0] table_w [loop_cfg_pkg::RATE_CODES];

   // Step per tick in Q16 mV; floor, but never zero so slow rates still move
   genvar i;
   generate
      for (i = 0; i < loop_cfg_pkg::RATE_CODES; i++) begin : g_entry
         localparam longint RAW = (loop_cfg_pkg::RATE_MVPS[i] * (64'd1 << loop_cfg_pkg::STEP_FRAC_BITS)
                                   * longint'(TICK_NS)) / loop_cfg_pkg::NS_PER_S;
         // Fast codes with a long tick overflow the step word, so saturate instead of wrapping
         localparam longint STEP_MAX = (64'd1 << loop_cfg_pkg::STEP_W) - 64'd1;
         localparam longint CLIPPED = (RAW < 64'd1) ? 64'd1 : ((RAW > STEP_MAX) ? STEP_MAX : RAW);
         assign table_w[i] = CLIPPED[loop_cfg_pkg::STEP_W-1:0];
      end
   endgenerate

   assign step = table_w[code];

endmodule // rate_step_rom
